// >>> verilog/txpic_ctrl.sv
// Contract
// [RULE1] Enable low: hold last code, no updates
// [RULE2] Enable high: update once per interval
// [RULE3] Interval is setting plus one; never zero
// [RULE4] Override enable drives stored override code
// [RULE5] Override code latched on strobe high-then-low
// [RULE6] Reserved select held at one externally
// [RULE7] Power-down high asynchronously idles controller; code synchronises it and idles two edges later
// [RULE8] Step bit four selects up or down
// [RULE9] Step low bits give magnitude 0..15
// [RULE10] Encoding select: binary or Gray magnitude
// [RULE11] Seven-bit accumulator wraps modulo 128
// [RULE12] User clock; counter restarts on enable rise
`timescale 1ns/10ps
module txpic_ctrl (
    input  wire logic                 CLK,          // Transmit user clock
    input  wire logic                 RESET,        // Synchronous, active high
    input  wire txpic_pkg::txpic_ctrl_t CTRL,       // Enable, override, step
    input  wire logic                 RSVD_SEL,     // Reserved select, tie high
    input  wire logic                 POWERDOWN,    // Asynchronous power-down
    input  wire logic [2:0]           UPD_SETTING,  // Update interval setting
    input  wire logic [7:0]           OVR_SETTING,  // Override code and strobe
    input  wire logic                 GRAY_SEL,     // Step magnitude is Gray
    output logic      [6:0]           PI_CODE,      // Code to the interpolator
    output logic                      PI_UPDATE,    // Code update pulse
    output logic      [1:0]           MODE          // Current controller mode
);
    // Registered state
    // Power-down is asynchronous, so it is synchronised before use
    logic       pd_meta;            // First synchroniser stage
    logic       pd_sync;            // Second synchroniser stage
    logic [2:0] cnt;                // Interval counter
    logic [6:0] acc;                // Stepping accumulator
    logic [6:0] ovr_code;           // Latched override code
    logic       strobe_q;           // Previous strobe bit
    logic       en_q;               // Previous enable
    // Combinational values
    logic [6:0] next_acc;           // Accumulator after one step
    logic [6:0] next_code;          // Code selected for output
    logic [3:0] mag;                // Decoded step magnitude
    logic [3:0] raw;                // Raw magnitude bits

    // Mode selection
    // Power-down idles the block exactly as a low enable does
    wire active    = CTRL.enable && !pd_sync;                           // RULE1
    // A rise restarts the interval, so the first update waits a full one
    wire en_rise   = CTRL.enable && !en_q;                              // RULE12
    wire cnt_done  = (cnt >= UPD_SETTING);                              // RULE3
    wire upd_tick  = active && !en_rise && cnt_done;                    // RULE2
    wire strobe_fall = strobe_q && !OVR_SETTING[txpic_pkg::OVR_STROBE_BIT]; // RULE5

    // Gray to binary on the magnitude when selected
    // Each binary bit is the XOR of all Gray bits at or above it
    assign raw = CTRL.step[3:0];
    assign mag = GRAY_SEL ? {raw[3], raw[3] ^ raw[2], raw[3] ^ raw[2] ^ raw[1],
                             raw[3] ^ raw[2] ^ raw[1] ^ raw[0]} : raw;  // RULE10 RULE9
    // Sum is cut to seven bits, which gives the wrap
    assign next_acc = CTRL.step[txpic_pkg::STEP_DIR_BIT]
                      ? 7'(acc + {3'h0, mag})
                      : 7'(acc - {3'h0, mag});                          // RULE8 RULE11
    // Override takes the stored code, stepping the next sum
    assign next_code = CTRL.ovr_enable ? ovr_code : next_acc;           // RULE4

    // Power-down synchroniser
    // No reset here: both stages flush within two edges of any reset
    always_ff @(posedge CLK) begin
        pd_meta <= POWERDOWN;                                           // RULE7
        pd_sync <= pd_meta;
    end

    // Interval counter, restarted on enable rise
    always_ff @(posedge CLK) begin
        // Held at zero while idle, on an enable rise and after each tick
        if (RESET || !active || en_rise || cnt_done) begin
            cnt <= txpic_pkg::CNT_RESET;                                // RULE12
        end else begin
            // Counts up to the setting; the tick edge makes setting plus one
            cnt <= 3'(cnt + 3'h1);
        end
    end

    // Override code latched on the falling strobe edge
    always_ff @(posedge CLK) begin
        if (RESET) begin
            strobe_q <= 1'b0;
            ovr_code <= txpic_pkg::CODE_RESET;
            en_q     <= 1'b0;
        end else begin
            // Previous levels for the two edge detectors
            strobe_q <= OVR_SETTING[txpic_pkg::OVR_STROBE_BIT];
            en_q     <= CTRL.enable;
            // A strobe held high stores nothing until it falls
            if (strobe_fall) begin
                ovr_code <= OVR_SETTING[6:0];                           // RULE5
            end
        end
    end

    // Accumulator and output code; held when idle
    always_ff @(posedge CLK) begin
        if (RESET) begin
            // Interpolator starts from code zero
            acc       <= txpic_pkg::CODE_RESET;
            PI_CODE   <= txpic_pkg::CODE_RESET;
            PI_UPDATE <= 1'b0;
        end else begin
            PI_UPDATE <= upd_tick;
            // Between ticks the code stands, which keeps it while disabled
            if (upd_tick) begin
                PI_CODE <= next_code;                                   // RULE2 RULE4
                // Frozen in override, so stepping resumes where it stopped
                if (!CTRL.ovr_enable) begin
                    acc <= next_acc;                                    // RULE11
                end
            end
        end
    end

    // Mode report
    always_comb begin
        if (!active) begin
            // Disabled or powered down
            MODE = txpic_pkg::TXPIC_IDLE;
        end else if (CTRL.ovr_enable) begin
            // Direct code in charge
            MODE = txpic_pkg::TXPIC_OVRD;
        end else begin
            // Stepping in charge
            MODE = txpic_pkg::TXPIC_STEP;
        end
    end

    // RSVD_SEL is accepted but has no function; fabric keeps it high
    // Driving it low changes nothing here; the far side must not rely on that
    logic unused_sel;                                                   // Reserved input sink
    assign unused_sel = RSVD_SEL;                                       // RULE6

    // Checks
    // Attempts that start while reset is still sampled high are masked: a
    // reset released at that edge rewrites the registers under the check

    // Steps of one update interval, for the two settings the bench uses
    sequence seq_tick_s2;
        upd_tick && UPD_SETTING == 3'h2;
    endsequence
    sequence seq_run_s2;
        (active && UPD_SETTING == 3'h2)[*3];
    endsequence
    sequence seq_tick_s7;
        upd_tick && UPD_SETTING == 3'h7;
    endsequence
    sequence seq_run_s7;
        (active && UPD_SETTING == 3'h7)[*8];
    endsequence

    // Disabled or powered down: the code must not move
    chk_hold_idle: assert property (@(posedge CLK) disable iff (RESET)
        (!active && !RESET) |=> $stable(PI_CODE))                       // RULE1
        else $error("code changed while disabled");

    // Setting two: one tick, two quiet cycles, then the next tick
    chk_interval_len: assert property (@(posedge CLK) disable iff (RESET)
        seq_tick_s2 ##1 seq_run_s2 |-> upd_tick)                        // RULE3
        else $error("update interval wrong");
    chk_interval_gap: assert property (@(posedge CLK) disable iff (RESET)
        seq_tick_s2 |=> (!upd_tick)[*2])                                // RULE3
        else $error("update came too early");

    // Setting seven: one tick, seven quiet cycles, then the next tick
    chk_interval_max: assert property (@(posedge CLK) disable iff (RESET)
        seq_tick_s7 ##1 seq_run_s7 |-> upd_tick)                        // RULE3
        else $error("long update interval wrong");
    chk_interval_quiet: assert property (@(posedge CLK) disable iff (RESET)
        seq_tick_s7 |=> (!upd_tick)[*7])                                // RULE3
        else $error("long interval cut short");

    // A tick is answered one edge later with the selected code
    chk_update_out: assert property (@(posedge CLK) disable iff (RESET)
        (upd_tick && !RESET) |=> PI_UPDATE && PI_CODE == $past(next_code)) // RULE2
        else $error("update not delivered");

    // The pulse lasts one cycle only while the setting is above zero; setting zero ticks every cycle
    chk_update_pulse: assert property (@(posedge CLK) disable iff (RESET)
        PI_UPDATE |=> !PI_UPDATE)                                       // RULE2
        else $error("update pulse too long");

    // Outside reset the code moves only together with the pulse
    chk_code_stands: assert property (@(posedge CLK) disable iff (RESET)
        (!$past(RESET) && $changed(PI_CODE)) |-> PI_UPDATE)             // RULE2
        else $error("code moved without update");

    // An override tick delivers the stored code, not the accumulator
    chk_ovr_drive: assert property (@(posedge CLK) disable iff (RESET)
        (upd_tick && CTRL.ovr_enable && !RESET) |=> PI_CODE == $past(ovr_code)) // RULE4
        else $error("override not applied");

    // A falling strobe stores the code that stands in that cycle
    chk_strobe_latch: assert property (@(posedge CLK) disable iff (RESET)
        (strobe_fall && !RESET) |=> ovr_code == $past(OVR_SETTING[6:0])) // RULE5
        else $error("override strobe missed");

    // Power-down seen at the pin blocks ticks once past both stages
    chk_pd_idle: assert property (@(posedge CLK) disable iff (RESET)
        POWERDOWN |-> ##2 !upd_tick)                                    // RULE7
        else $error("update during power-down");

    // Stepping moves the accumulator by the decoded size, with wrap
    chk_step_dir: assert property (@(posedge CLK) disable iff (RESET)
        (upd_tick && !CTRL.ovr_enable && !RESET) |=>
        acc == 7'($past(acc) + ($past(CTRL.step[4]) ? {3'h0, $past(mag)}
                                 : 7'(-{3'h0, $past(mag)}))))           // RULE8 RULE11
        else $error("step wrong");

    // Re-encoding the decoded size must give back the Gray input
    chk_gray_mag: assert property (@(posedge CLK) disable iff (RESET)
        GRAY_SEL |-> 4'(mag ^ (mag >> 1)) == raw)                       // RULE10
        else $error("gray decode wrong");

    // An enable rise never ticks and restarts the counter
    chk_rise_restart: assert property (@(posedge CLK) disable iff (RESET)
        (en_rise && active) |-> !upd_tick ##1 cnt == 3'h0)              // RULE12
        else $error("counter not restarted");
endmodule

// >>> pkg/txpic_pkg.sv
package txpic_pkg;
    // Code width toward the phase interpolator
    localparam int CODE_W = 7;
    // Step input layout
    localparam int STEP_DIR_BIT = 4;
    localparam int STEP_MAG_W = 4;
    // Update interval setting width
    localparam int UPD_W = 3;
    // Override setting layout: strobe is the top bit
    localparam int OVR_STROBE_BIT = 7;
    // Reset values
    localparam logic [6:0] CODE_RESET = 7'h00;
    localparam logic [2:0] CNT_RESET = 3'h0;

    // Fabric-side control group
    typedef struct packed {
        logic       enable;     // Stepping enable
        logic       ovr_enable; // Direct code override
        logic [4:0] step;       // Direction and magnitude
    } txpic_ctrl_t;

    // Controller mode
    typedef enum logic [1:0] {
        TXPIC_IDLE,
        TXPIC_STEP,
        TXPIC_OVRD
    } txpic_mode_t;
endpackage

// >>> dv/txpic_fabric.sv
`timescale 1ns/10ps
// Fabric-side model: owns the override strobe and the reserved select
module txpic_fabric (
    input  wire logic       clk,      // User clock
    input  wire logic       load,     // One-cycle request to hand over a code
    input  wire logic [6:0] code,     // Override code to hand over
    output logic      [7:0] ovr,      // Override setting toward the block
    output logic            rsvd_sel  // Reserved select
);
    // Reserved select never leaves one
    assign rsvd_sel = 1'h1;
    initial ovr = 8'h00;
    // Strobe high for one cycle, then low; code kept so it is stable when latched
    always @(posedge clk) begin
        ovr <= {load, load ? code : ovr[6:0]};
    end
endmodule

// >>> dv/txpic_ctrl_tb_top.sv
`timescale 1ns/10ps
module txpic_ctrl_tb_top;
    logic                   clk = 1'h0;   // User clock
    logic                   rst = 1'h1;   // Reset
    logic                   pd = 1'h0;    // Power-down
    logic                   gray = 1'h0;  // Gray step select
    logic                   load = 1'h0;  // Override load request
    logic [2:0]             upd = 3'h2;   // Interval setting, never zero
    logic [6:0]             code = 7'h00; // Override code
    logic [6:0]             pi_code;      // Code seen at the interpolator
    logic                   pi_upd;       // Update pulse
    logic [1:0]             mode;         // Mode report
    logic [7:0]             ovr;          // Override setting from the fabric
    logic                   rsel;         // Reserved select from the fabric
    txpic_pkg::txpic_ctrl_t ctrl = '0;    // Enable, override, step
    int                     num_errors = 0;
    int                     n_tests = 0;
    int                     cyc = 0;
    int                     n;
    always #2.5 clk = ~clk;
    txpic_fabric u_fab (.clk(clk), .load(load), .code(code), .ovr(ovr), .rsvd_sel(rsel));
    txpic_ctrl u_dut (.CLK(clk), .RESET(rst), .CTRL(ctrl), .RSVD_SEL(rsel), .POWERDOWN(pd),
        .UPD_SETTING(upd), .OVR_SETTING(ovr), .GRAY_SEL(gray), .PI_CODE(pi_code),
        .PI_UPDATE(pi_upd), .MODE(mode));
    // Hang guard: the whole run needs well under 300 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            num_errors++;
            summarize();
        end
    end
    task check(logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Counts cycles to the next update pulse, sampled mid-cycle to avoid edge races
    task wait_upd();
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (pi_upd !== 1'h1 && n < 40);
    endtask
    // No update pulse may show for a dozen cycles
    task quiet();
        int k;
        k = 0;
        repeat (12) begin
            @(negedge clk);
            if (pi_upd !== 1'h0) k++;
        end
        check(k, 0);
    endtask
    // Binary up-steps at interval setting plus one
    task step_up();
        @(posedge clk) ctrl <= '{1'h1, 1'h0, 5'h15};
        wait_upd();
        check(pi_code, 7'h05);
        check(mode, txpic_pkg::TXPIC_STEP);
        wait_upd();
        check(n, 3);
        check(pi_code, 7'h0A);
    endtask
    // Disabled block holds its code
    task hold();
        @(posedge clk) ctrl.enable <= 1'h0;
        quiet();
        check(pi_code, 7'h0A);
        check(mode, txpic_pkg::TXPIC_IDLE);
    endtask
    // Gray magnitude 2 means 3; stepping down from 10 wraps below zero
    task gray_down();
        @(posedge clk) begin
            gray <= 1'h1;
            upd <= 3'h7;
            ctrl <= '{1'h1, 1'h0, 5'h02};
        end
        repeat (4) wait_upd();
        check(n, 8);
        check(pi_code, 7'h7E);
    endtask
    // Strobed override code reaches the interpolator, then power-down freezes it
    task override_pd();
        @(posedge clk) begin
            ctrl <= '{1'h1, 1'h1, 5'h00};
            code <= 7'h55;
            load <= 1'h1;
        end
        @(posedge clk) load <= 1'h0;
        wait_upd();
        check(pi_code, 7'h55);
        check(mode, txpic_pkg::TXPIC_OVRD);
        @(posedge clk) pd <= 1'h1;
        repeat (4) @(posedge clk);
        quiet();
        check(pi_code, 7'h55);
        check(mode, txpic_pkg::TXPIC_IDLE);
    endtask
    // Reset in mid-run clears the code and the stored override code
    task reset_mid();
        @(posedge clk) begin
            rst <= 1'h1;
            pd  <= 1'h0;
        end
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        @(negedge clk);
        check(pi_code, txpic_pkg::CODE_RESET);
        check(pi_upd, 1'h0);
        wait_upd();
        check(n, 9);
        check(pi_code, txpic_pkg::CODE_RESET);
    endtask
    task summarize();
        $display("errors=%0d checks=%0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        step_up();
        hold();
        gray_down();
        override_pd();
        reset_mid();
        summarize();
    end
endmodule
